// *** rcc_board.sv ***
// Board side: pulled-up reset line, external reset agent, strap resistors
`timescale 1ns/10ps
module rcc_board (
	input wire logic clk_in,
	input wire logic oe_in,
	input wire logic drv_in,
	input wire logic ext_req_in,
	input wire logic [3:0] strap_in,
	output logic line_out,
	output logic [3:0] straps_out
);
	logic [5:0] hold_reg = 6'h00;
	logic tog_reg = 1'b0;
	// Agent keeps the line low 32 clocks once asked
	always_ff @(posedge clk_in) begin
		hold_reg <= ext_req_in ? 6'h20 : hold_reg - 6'(hold_reg != 6'h00);
		tog_reg <= ~tog_reg;
	end
	// Open drain: any puller wins, else the pull-up negates
	assign line_out = ~((oe_in & ~drv_in) | (hold_reg != 6'h00));
	// Straps valid only while line low; pins toggle otherwise
	assign straps_out = line_out ? ~strap_in ^ {4{tog_reg}} : strap_in;
endmodule

// *** rcc_ctrl.sv ***
// Reset cause controller: sequencer, open-drain line, straps, APB regs
// What this block does
// - Power-on resets everything except the real-time clock
// - Hard reset spares clock logic and error capture
// - Hard-reset line is open-drain, board pulls up
// - External hard-reset assertion accepted asynchronously
// - External assertion seen only when not driving
// - Drive line low throughout every flow
// - Hard reset aborts transactions, restores defaults
// - Sample four strap pins during power-on
// - Sample straps only after stable clock
// - Straps are inputs in reset, functional after
// - Six reset sources, action by source
// - Software-readable record of last reset cause
// - Enabled watchdog expiry starts hard reset
// - Enabled bus-monitor timeout starts hard reset
// - Checkstop with enable set starts hard reset
// - Command register write starts hard reset
// - Identify cause, synchronise asynchronous causes
// - Every source resets internal logic; clock logic and error capture only on power-on
// - Every source reloads config, drives line, resets core
// - No source raises the soft reset interrupt
// - Line stays asserted through configuration after power-on
// - Hard reset reuses latched straps, no resample
// - Wait 16 cycles after negation before rechecking
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module rcc_ctrl (
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic POWER_ON_INPUT_N_IN,
	input wire logic HARD_RESET_LINE_IN,
	output logic HARD_RESET_LINE_OUT,
	output logic HARD_RESET_LINE_OE_OUT,
	input wire logic [3:0] BOOT_SRC_IN,
	input wire logic WDG_EXPIRE_IN,
	input wire logic BMON_TIMEOUT_IN,
	input wire logic CHECKSTOP_IN,
	input wire logic CFG_DONE_IN,
	output logic FULL_RESET_N_OUT,
	output logic HARD_RESET_N_OUT,
	output logic CORE_RESET_N_OUT,
	output logic CFG_LOAD_OUT,
	output logic STRAP_FUNC_OUT,
	output logic [3:0] BOOT_SRC_OUT,
	output logic SOFT_RESET_INT_OUT,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	import rcc_pkg::*;

	logic por_sync;
	logic line_sync;
	rcc_state_t state_reg, state_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [5:0] cause_reg, cause_next;
	logic [2:0] mode_reg;
	logic [3:0] strap_reg;
	logic strap_taken_reg;
	logic [4:0] settle_reg;
	logic sw_req_reg;
	logic drive_reg;
	logic por_flow_reg;
	logic [31:0] prdata_next;

	// Power-on and external line cross through synchronisers
	rcc_sync u_por_sync (
		.clk_in(MCLK_IN),
		.nrst_in(NRST_IN),
		.d_in(~POWER_ON_INPUT_N_IN),
		.q_out(por_sync)
	);
	rcc_sync u_line_sync (
		.clk_in(MCLK_IN),
		.nrst_in(NRST_IN),
		.d_in(~HARD_RESET_LINE_IN),
		.q_out(line_sync)
	);

	// Internal causes gated by their enables
	wire wdg_hit = WDG_EXPIRE_IN & mode_reg[RCC_M_WDG_EN];
	wire bmon_hit = BMON_TIMEOUT_IN & mode_reg[RCC_M_BMON_EN];
	wire cks_hit = CHECKSTOP_IN & mode_reg[RCC_M_CKS_EN];
	// Line low while we are not pulling it means an external agent
	wire idle_st = (state_reg == RCC_ST_IDLE);
	wire ext_hit = idle_st & line_sync & ~drive_reg;
	wire int_hit = wdg_hit | bmon_hit | cks_hit | sw_req_reg;
	wire any_hit = idle_st & (ext_hit | int_hit);

	// APB decode, zero wait states
	wire apb_wr = PSEL & PENABLE & PWRITE;
	wire apb_rd = PSEL & ~PWRITE;
	wire hit_cause = (PADDR == RCC_CAUSE_OFS);
	wire hit_cmd = (PADDR == RCC_CMD_OFS);
	wire hit_mode = (PADDR == RCC_MODE_OFS);
	wire hit_strap = (PADDR == RCC_STRAP_OFS);
	wire hit_ctrl = (PADDR == RCC_CTRL_OFS);
	wire hit_any = hit_cause | hit_cmd | hit_mode | hit_strap | hit_ctrl;
	wire sw_write = apb_wr & hit_cmd & (PWDATA == RCC_CMD_KEY);

	// Cause record, fixed priority ext > wdg > bmon > cks > sw
	always_comb begin
		cause_next = cause_reg;
		if (any_hit) begin
			cause_next = '0;
			if (ext_hit)
				cause_next[RCC_C_EXT] = 1'b1;
			else if (wdg_hit)
				cause_next[RCC_C_WDG] = 1'b1;
			else if (bmon_hit)
				cause_next[RCC_C_BMON] = 1'b1;
			else if (cks_hit)
				cause_next[RCC_C_CKS] = 1'b1;
			else
				cause_next[RCC_C_SW] = 1'b1;
		end
	end

	// Sequencer: hold line, wait config done, release, rearm gap
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			RCC_ST_IDLE: begin
				if (any_hit)
					state_next = RCC_ST_HOLD;
			end
			RCC_ST_HOLD: begin
				// Config loader must finish before release
				if (CFG_DONE_IN)
					state_next = RCC_ST_RELEASE;
			end
			RCC_ST_RELEASE: begin
				// Pull-up must be seen before the rearm count
				if (!line_sync) begin
					state_next = RCC_ST_REARM;
					cnt_next = '0;
				end
			end
			RCC_ST_REARM: begin
				cnt_next = cnt_reg + 5'h01;
				if (cnt_reg == RCC_REARM_LAST)
					state_next = RCC_ST_IDLE;
			end
			default: state_next = RCC_ST_IDLE;
		endcase
	end

	// State; power-on overrides everything and restarts the hold
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_reg <= RCC_ST_HOLD;
			cnt_reg <= '0;
		end else if (por_sync) begin
			state_reg <= RCC_ST_HOLD;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Cause register; power-on wins over any other record
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			cause_reg <= RCC_CAUSE_RST;
		else if (por_sync)
			cause_reg <= RCC_CAUSE_RST;
		else
			cause_reg <= cause_next;
	end

	// Mode and software request; cleared by hard reset, one-shot
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			mode_reg <= RCC_MODE_RST;
			sw_req_reg <= 1'b0;
		end else if (state_reg == RCC_ST_HOLD) begin
			mode_reg <= RCC_MODE_RST;
			sw_req_reg <= 1'b0;
		end else begin
			if (apb_wr & hit_mode)
				mode_reg <= PWDATA[2:0];
			// Request waits for idle so a rearm gap does not lose it
			sw_req_reg <= sw_write | (sw_req_reg & ~idle_st);
		end
	end

	// Strap capture: only during power-on, after settle clocks
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			strap_reg <= RCC_STRAP_RST;
			strap_taken_reg <= 1'b0;
			settle_reg <= '0;
		end else if (por_sync) begin
			if (settle_reg != RCC_SETTLE_LAST)
				settle_reg <= settle_reg + 5'h01;
			else begin
				strap_reg <= BOOT_SRC_IN;
				strap_taken_reg <= 1'b1;
			end
		end else begin
			// Hard reset keeps the latched value
			settle_reg <= '0;
		end
	end

	// Power-on flow flag: clock logic reset only on this path
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			por_flow_reg <= 1'b1;
		else if (por_sync)
			por_flow_reg <= 1'b1;
		else if (state_reg == RCC_ST_RELEASE)
			por_flow_reg <= 1'b0;
	end

	// Open-drain drive: only low or released
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			drive_reg <= 1'b1;
			HARD_RESET_LINE_OUT <= 1'b0;
			HARD_RESET_LINE_OE_OUT <= 1'b1;
		end else begin
			drive_reg <= por_sync | (state_next == RCC_ST_HOLD);
			HARD_RESET_LINE_OUT <= 1'b0;
			HARD_RESET_LINE_OE_OUT <= por_sync |
				(state_next == RCC_ST_HOLD);
		end
	end

	// Reset outputs to the rest of the chip
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			FULL_RESET_N_OUT <= 1'b0;
			HARD_RESET_N_OUT <= 1'b0;
			CORE_RESET_N_OUT <= 1'b0;
			CFG_LOAD_OUT <= 1'b0;
			STRAP_FUNC_OUT <= 1'b0;
			BOOT_SRC_OUT <= RCC_STRAP_RST;
			SOFT_RESET_INT_OUT <= 1'b0;
		end else begin
			// Clock logic and error capture reset only on power-on
			FULL_RESET_N_OUT <= ~por_sync;
			HARD_RESET_N_OUT <= (state_next != RCC_ST_HOLD) &
				~por_sync;
			CORE_RESET_N_OUT <= (state_next != RCC_ST_HOLD) &
				~por_sync;
			// Loader runs once power-on has dropped and straps are held
			CFG_LOAD_OUT <= (state_next == RCC_ST_HOLD) & ~por_sync &
				strap_taken_reg;
			STRAP_FUNC_OUT <= idle_st & ~drive_reg;
			BOOT_SRC_OUT <= strap_reg;
			SOFT_RESET_INT_OUT <= 1'b0;
		end
	end

	// Read mux
	always_comb begin
		prdata_next = '0;
		if (hit_cause)
			prdata_next[5:0] = cause_reg;
		else if (hit_mode)
			prdata_next[2:0] = mode_reg;
		else if (hit_strap)
			prdata_next[3:0] = strap_reg;
		else if (hit_ctrl)
			prdata_next[RCC_CTRL_DONE] = idle_st;
	end

	// APB answer registered: ready in the first access cycle
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PRDATA <= apb_rd ? prdata_next : '0;
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~hit_any;
		end
	end
endmodule

// *** rcc_ctrl_asserts.sv ***
// Port-level assertions for the reset cause controller
`timescale 1ns/10ps
module rcc_ctrl_asserts
	import rcc_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic POWER_ON_INPUT_N_IN,
	input wire logic CFG_DONE_IN,
	input wire logic HARD_RESET_LINE_OUT,
	input wire logic HARD_RESET_LINE_OE_OUT,
	input wire logic FULL_RESET_N_OUT,
	input wire logic HARD_RESET_N_OUT,
	input wire logic CORE_RESET_N_OUT,
	input wire logic CFG_LOAD_OUT,
	input wire logic STRAP_FUNC_OUT,
	input wire logic [3:0] BOOT_SRC_OUT,
	input wire logic SOFT_RESET_INT_OUT,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	// Short aliases keep the properties readable
	wire oe = HARD_RESET_LINE_OE_OUT;
	wire setup = PSEL && !PENABLE;
	default clocking @(posedge MCLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	chk_line_low_only: assert property (!HARD_RESET_LINE_OUT)
		else $error("line driven high");
	chk_no_soft_int: assert property (!SOFT_RESET_INT_OUT)
		else $error("soft interrupt raised");
	chk_apb_ready: assert property (setup |=> PREADY)
		else $error("no ready");
	chk_unmapped_err: assert property (setup && PADDR > RCC_CTRL_OFS
		|=> PSLVERR && PRDATA == 32'h0) else $error("unmapped accepted");
	chk_flow_outputs: assert property ($rose(oe)
		|-> !HARD_RESET_N_OUT && !CORE_RESET_N_OUT && CFG_LOAD_OUT)
		else $error("flow outputs wrong");
	chk_clock_spared: assert property ($rose(oe) && POWER_ON_INPUT_N_IN
		|-> FULL_RESET_N_OUT) else $error("full reset on hard reset");
	chk_hold_till_done: assert property (oe && !CFG_DONE_IN |=> oe)
		else $error("line released early");
	chk_straps_input: assert property (oe && $past(oe) |-> !STRAP_FUNC_OUT)
		else $error("straps functional in flow");
	chk_strap_hold: assert property (POWER_ON_INPUT_N_IN [*4]
		|=> $stable(BOOT_SRC_OUT)) else $error("straps resampled");
	chk_rearm_quiet: assert property ($fell(oe) |=> !oe [*8])
		else $error("flow restarted in rearm");
	cov_flow: cover property ($rose(oe));
	cov_release: cover property ($fell(oe));
	cov_refused: cover property (PREADY && PSLVERR);
endmodule
bind rcc_ctrl rcc_ctrl_asserts i_rcc_ctrl_asserts (.MCLK_IN, .NRST_IN,
	.POWER_ON_INPUT_N_IN, .CFG_DONE_IN, .HARD_RESET_LINE_OUT,
	.HARD_RESET_LINE_OE_OUT, .FULL_RESET_N_OUT, .HARD_RESET_N_OUT,
	.CORE_RESET_N_OUT, .CFG_LOAD_OUT, .STRAP_FUNC_OUT, .BOOT_SRC_OUT,
	.SOFT_RESET_INT_OUT, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY,
	.PSLVERR);

// *** rcc_pkg.sv ***
// Package of constants and types for the reset cause controller
package rcc_pkg;
	// APB register byte offsets
	localparam logic [7:0] RCC_CAUSE_OFS = 8'h00;
	localparam logic [7:0] RCC_CMD_OFS = 8'h04;
	localparam logic [7:0] RCC_MODE_OFS = 8'h08;
	localparam logic [7:0] RCC_STRAP_OFS = 8'h0c;
	localparam logic [7:0] RCC_CTRL_OFS = 8'h10;
	// Cause register bit positions (one-hot record)
	localparam int RCC_C_POR = 0;
	localparam int RCC_C_EXT = 1;
	localparam int RCC_C_WDG = 2;
	localparam int RCC_C_BMON = 3;
	localparam int RCC_C_CKS = 4;
	localparam int RCC_C_SW = 5;
	localparam int RCC_NCAUSE = 6;
	// Mode register fields
	localparam int RCC_M_WDG_EN = 0;
	localparam int RCC_M_BMON_EN = 1;
	localparam int RCC_M_CKS_EN = 2;
	localparam logic [2:0] RCC_MODE_RST = 3'h0;
	// Control register: bit 0 marks the sequencer back in idle, rearm gap over
	localparam int RCC_CTRL_DONE = 0;
	// Command register key that starts a software hard reset
	localparam logic [31:0] RCC_CMD_KEY = 32'h00000001;
	// Reset values
	localparam logic [5:0] RCC_CAUSE_RST = 6'h01;
	localparam logic [3:0] RCC_STRAP_RST = 4'h0;
	// Timing
	localparam int RCC_CLK_MHZ = 100;
	localparam int RCC_POR_MIN_CYC = 32;
	localparam int RCC_EXT_MIN_CYC = 32;
	localparam int RCC_REARM_CYC = 16;
	// Strap sampling waits this many stable clocks into power-on
	localparam int RCC_STRAP_SETTLE = 8;
	localparam logic [4:0] RCC_REARM_LAST = 5'(RCC_REARM_CYC - 1);
	localparam logic [4:0] RCC_SETTLE_LAST = 5'(RCC_STRAP_SETTLE - 1);
	typedef enum logic [1:0] {
		RCC_ST_IDLE,
		RCC_ST_HOLD,
		RCC_ST_RELEASE,
		RCC_ST_REARM
	} rcc_state_t;
endpackage

// *** rcc_sync.sv ***
// Two-stage synchroniser for the asynchronous reset pins
`timescale 1ns/10ps
module rcc_sync (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta_reg;
	// First stage only feeds the second, keeps metastability contained
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule

// *** reset_cause_controller_tb.sv ***
// Self-checking bench for the reset cause controller
`timescale 1ns/10ps
module reset_cause_controller_tb;
	import rcc_pkg::*;
	logic clk, rst_n, por_n, wdg, bmon, cks, done, ext_req, line, oe, drv;
	logic psel, penable, pwrite, pready, pslverr, full_n, hard_n, core_n;
	logic cfg_load, strap_func;
	logic [3:0] strap_val, straps, boot_src, s0;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	int err_total, checked;
	rcc_ctrl i_rcc_ctrl (
		.MCLK_IN(clk), .NRST_IN(rst_n), .POWER_ON_INPUT_N_IN(por_n),
		.HARD_RESET_LINE_IN(line), .HARD_RESET_LINE_OUT(drv),
		.HARD_RESET_LINE_OE_OUT(oe), .BOOT_SRC_IN(straps),
		.WDG_EXPIRE_IN(wdg), .BMON_TIMEOUT_IN(bmon), .CHECKSTOP_IN(cks),
		.CFG_DONE_IN(done), .FULL_RESET_N_OUT(full_n),
		.HARD_RESET_N_OUT(hard_n), .CORE_RESET_N_OUT(core_n),
		.CFG_LOAD_OUT(cfg_load), .STRAP_FUNC_OUT(strap_func),
		.BOOT_SRC_OUT(boot_src), .SOFT_RESET_INT_OUT(), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr)
	);
	rcc_board i_rcc_board (
		.clk_in(clk), .oe_in(oe), .drv_in(drv), .ext_req_in(ext_req),
		.strap_in(strap_val), .line_out(line), .straps_out(straps)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Priority watchdog, bus monitor, checkstop among enabled causes
	function automatic logic [31:0] want(input logic [2:0] en, c);
		logic [2:0] a;
		a = en & c;
		return a[0] ? 32'h04 : a[1] ? 32'h08 : a[2] ? 32'h10 : 32'h0;
	endfunction
	task automatic cmp(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_total++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		cmp(r, x);
		cmp(e, xe);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		cmp(e, 1'b0);
	endtask
	// Ends a flow, then lets the rearm window run out
	task automatic finish_flow(input int lag);
		int n;
		n = 0;
		repeat (lag) @(posedge clk);
		done <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (oe !== 1'b0 && n < 20);
		done <= 1'b0;
		repeat (30) @(posedge clk);
		cmp({full_n, hard_n, core_n, strap_func, oe}, 5'h1e);
		rd(RCC_CTRL_OFS, 32'h1, 1'b0);
		rd(RCC_STRAP_OFS, {28'h0, s0}, 1'b0);
	endtask
	task automatic hit(input logic [2:0] en, c);
		logic [31:0] w;
		w = want(en, c);
		wr(RCC_MODE_OFS, {29'h0, en});
		rd(RCC_MODE_OFS, {29'h0, en}, 1'b0);
		seed = lfsr(seed);
		strap_val <= seed[3:0];
		{cks, bmon, wdg} <= c;
		repeat (2) @(posedge clk);
		{cks, bmon, wdg} <= 3'h0;
		repeat (3) @(posedge clk);
		cmp(oe, w != 0);
		if (w != 0) begin
			cmp({full_n, hard_n, core_n, cfg_load}, 4'h9);
			finish_flow(5);
			rd(RCC_CAUSE_OFS, w, 1'b0);
			rd(RCC_MODE_OFS, 32'h0, 1'b0);
		end
	endtask
	task automatic final_report;
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Free-running 100 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		final_report;
	end
	initial begin
		{rst_n, por_n, wdg, bmon, cks, done, ext_req} = 7'h0;
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		err_total = 0;
		checked = 0;
		seed = lfsr(32'h5d26938e);
		strap_val = seed[3:0];
		s0 = seed[3:0];
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (40) @(posedge clk);
		cmp({full_n, hard_n, core_n, strap_func, oe}, 5'h01);
		por_n <= 1'b1;
		finish_flow(10);
		rd(RCC_CAUSE_OFS, 32'h01, 1'b0);
		cmp(boot_src, s0);
		rd(8'h40, 32'h0, 1'b1);
		hit(3'h0, 3'h7);
		hit(3'h1, 3'h1);
		hit(3'h2, 3'h2);
		hit(3'h4, 3'h4);
		hit(3'h7, 3'h6);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			hit(seed[2:0], seed[5:3]);
		end
		wr(RCC_CMD_OFS, RCC_CMD_KEY);
		repeat (4) @(posedge clk);
		cmp(oe, 1'b1);
		finish_flow(5);
		rd(RCC_CAUSE_OFS, 32'h20, 1'b0);
		ext_req <= 1'b1;
		@(posedge clk);
		ext_req <= 1'b0;
		repeat (8) @(posedge clk);
		cmp(oe, 1'b1);
		finish_flow(40);
		rd(RCC_CAUSE_OFS, 32'h02, 1'b0);
		final_report;
	end
endmodule
